// ===== rtl/lse_pkg.sv
// Shared constants and types of the layer-2 switching engine
package lse_pkg;
  // Port and table geometry
  localparam int NPORTS    = 7;
  localparam int PW        = 3;
  localparam int MAC_W     = 48;
  localparam int TBL_AW    = 12;
  localparam int HDL_W     = 8;
  localparam int LEN_W     = 11;
  localparam int VID_W     = 12;
  localparam int BCL_W     = 16;
  localparam logic [TBL_AW-1:0] TBL_LAST = 12'hFFF;
  localparam logic [TBL_AW-1:0] TBL_MAX  = 12'hFA0;  // 4000 learned entries
  // Frame checks
  localparam logic [LEN_W-1:0] MAX_LEN = 11'h5F2;    // 1522 bytes
  localparam logic [LEN_W-1:0] MIN_LEN = 11'h040;    // 64 bytes
  localparam int MCAST_BIT = 40;                     // Group bit of first octet
  localparam logic [MAC_W-1:0] BCAST_MAC = 48'hFFFF_FFFF_FFFF;
  localparam int PCP_HI_BIT = 2;                     // Priority 4-7 has this bit set
  // Entry kinds
  localparam logic [1:0] KIND_LEARN  = 2'h0;
  localparam logic [1:0] KIND_AGENT  = 2'h1;
  localparam logic [1:0] KIND_STATIC = 2'h2;
  // Aging
  localparam logic [1:0] AGE_LIMIT = 2'h3;
  localparam longint AGE_STEPS     = 3;
  localparam longint CLK_PERIOD_NS = 10;
  localparam longint NS_PER_S      = 1000000000;
  localparam longint AGING_TIME_S  = 30;
  localparam longint BCL_WINDOW_S  = 1;
  localparam longint AGING_CYC     = AGING_TIME_S * NS_PER_S / CLK_PERIOD_NS;
  localparam longint SWEEP_CYC     = AGING_CYC / (AGE_STEPS * (longint'(1) << TBL_AW));
  localparam longint SEC_CYC       = BCL_WINDOW_S * NS_PER_S / CLK_PERIOD_NS;

  typedef struct packed {
    logic              valid;
    logic [1:0]        kind;
    logic [MAC_W-1:0]  mac;
    logic [NPORTS-1:0] ports;
    logic              drop;
    logic [1:0]        age;
  } lse_entry_t;

  typedef struct packed {
    logic [HDL_W-1:0]  hdl;
    logic [NPORTS-1:0] ports;
  } lse_fwd_t;

  typedef enum logic [2:0] {
    ST_CLEAR = 3'b000,
    ST_IDLE  = 3'b001,
    ST_MGMT  = 3'b010,
    ST_LKDA  = 3'b011,
    ST_LKSA  = 3'b100,
    ST_AGE   = 3'b101
  } lse_state_t;
endpackage

// ===== rtl/lse_engine.sv
// Forwarding decision core: checks, learning, aging, filters, queues, limiter
//
// Contract
// - Drop frames over 1522 bytes, under 64 bytes, or with bad CRC.
// - Learn source addresses; forward only unknown, learned-there, multicast or broadcast.
// - Address table holds up to 4000 learned entries.
// - Remove learned entries unrefreshed beyond 30 seconds.
// - Unknown destination is flooded to all ports; the code floods to all ports except the receiving port.
// - Known destination goes only to its associated port.
// - Reset clears every learned entry.
// - Filter match on destination forwards or rejects per port.
// - Table holds static entries plus learned and agent dynamic kinds.
// - Static addresses are installed into the dynamic lookup table automatically.
// - Learning never overwrites a statically configured address.
// - Priority 0-3 goes to low queue, 4-7 to high queue.
// - No low-queue frame leaves while a high-queue frame waits.
// - Under overload low-priority traffic is discarded first.
// - Recognise the 4-byte VLAN tag between source address and type.
// - Always use tag priority; use VLAN identifier only when VLANs enabled.
// - VLAN identifier 0 means priority-tagged, no VLAN membership.
// - Full-duplex flow-controlled ports request pause when egress nears overflow.
// - Half-duplex flow-controlled ports force collisions when egress nears overflow.
// - Mirror source traffic to destination port; destination discards received frames.
// - Per-port broadcasts per second capped; excess broadcasts to that port rejected.
// - One global enable switches broadcast limiting on all ports.
`timescale 1ns/10ps
module lse_engine #(
  parameter int unsigned SWEEP_CYC = 32'(lse_pkg::SWEEP_CYC),
  parameter int unsigned SEC_CYC   = 32'(lse_pkg::SEC_CYC)
) (
  input  wire logic                                       CLK_SYS,
  input  wire logic                                       NRST,
  // Frame summary from the ingress MAC, given after the frame is fully stored
  input  wire logic                                       RX_VALID,
  output logic                                            RX_READY,
  input  wire logic [lse_pkg::HDL_W-1:0]                  RX_HANDLE,
  input  wire logic [lse_pkg::PW-1:0]                     RX_PORT,
  input  wire logic [lse_pkg::LEN_W-1:0]                  RX_LEN,
  input  wire logic                                       RX_CRC_OK,
  input  wire logic [lse_pkg::MAC_W-1:0]                  RX_DA,
  input  wire logic [lse_pkg::MAC_W-1:0]                  RX_SA,
  input  wire logic                                       RX_TAGGED,
  input  wire logic [2:0]                                 RX_PCP,
  input  wire logic [lse_pkg::VID_W-1:0]                  RX_VID,
  // Forward decisions to the egress side
  output logic                                            FWD_VALID,
  input  wire logic                                       FWD_READY,
  output logic [lse_pkg::HDL_W-1:0]                       FWD_HANDLE,
  output logic [lse_pkg::NPORTS-1:0]                      FWD_PORTS,
  output logic                                            FWD_HIGH,
  output logic                                            DROP_VALID,
  output logic [lse_pkg::HDL_W-1:0]                       DROP_HANDLE,
  // Management writes of static and agent entries
  input  wire logic                                       TBL_WE,
  output logic                                            TBL_ACK,
  input  wire logic [lse_pkg::MAC_W-1:0]                  TBL_MAC,
  input  wire logic                                       TBL_AGENT,
  input  wire logic [lse_pkg::NPORTS-1:0]                 TBL_PORTS,
  input  wire logic                                       TBL_DROP,
  // Configuration
  input  wire logic                                       VLAN_EN,
  input  wire logic [lse_pkg::VID_W-1:0]                  VLAN_ID,
  input  wire logic [lse_pkg::NPORTS-1:0]                 VLAN_PORTS,
  input  wire logic                                       MIR_EN,
  input  wire logic [lse_pkg::PW-1:0]                     MIR_SRC,
  input  wire logic [lse_pkg::PW-1:0]                     MIR_DST,
  input  wire logic                                       BCL_EN,
  input  wire logic [lse_pkg::NPORTS-1:0][lse_pkg::BCL_W-1:0] BCL_MAX,
  input  wire logic [lse_pkg::NPORTS-1:0]                 FC_EN,
  input  wire logic [lse_pkg::NPORTS-1:0]                 FDX,
  input  wire logic [lse_pkg::NPORTS-1:0]                 EGR_NEAR_FULL,
  // Flow control requests and status
  output logic [lse_pkg::NPORTS-1:0]                      PAUSE_REQ,
  output logic [lse_pkg::NPORTS-1:0]                      JAM_REQ,
  output logic [lse_pkg::TBL_AW-1:0]                      LEARN_COUNT,
  output logic                                            INIT_DONE
);
  localparam int NP = lse_pkg::NPORTS;

  typedef struct packed {
    lse_pkg::lse_state_t                  st;
    logic [lse_pkg::TBL_AW-1:0]           ptr;
    logic [31:0]                          swp_cnt;
    logic                                 swp_pend;
    logic [31:0]                          sec_cnt;
    logic [lse_pkg::TBL_AW-1:0]           n_learn;
    logic [lse_pkg::HDL_W-1:0]            f_hdl;
    logic [lse_pkg::PW-1:0]               f_port;
    logic                                 f_bad;
    logic                                 f_tag;
    logic [2:0]                           f_pcp;
    logic [lse_pkg::VID_W-1:0]            f_vid;
    logic [lse_pkg::MAC_W-1:0]            f_da;
    logic [lse_pkg::MAC_W-1:0]            f_sa;
    lse_pkg::lse_entry_t                  da_ent;
    logic [NP-1:0][lse_pkg::BCL_W-1:0]    bc_cnt;
    lse_pkg::lse_fwd_t [1:0]              hq;
    lse_pkg::lse_fwd_t [1:0]              lq;
    logic [1:0]                           hn;
    logic [1:0]                           ln;
    logic                                 drop_v;
    logic [lse_pkg::HDL_W-1:0]            drop_h;
    logic [NP-1:0]                        pause;
    logic [NP-1:0]                        jam;
  } lse_state_reg_t;

  lse_state_reg_t               s_q;
  lse_state_reg_t               s_d;
  lse_pkg::lse_entry_t          tbl [0:(1<<lse_pkg::TBL_AW)-1];
  lse_pkg::lse_entry_t          rd_q;
  lse_pkg::lse_entry_t          wd;
  logic                         we;
  logic [lse_pkg::TBL_AW-1:0]   wa;
  logic [lse_pkg::TBL_AW-1:0]   ra;
  logic                         pop_h;
  logic                         pop_l;
  logic                         hit;
  logic                         hi;
  logic                         bcast;
  logic                         near;
  logic [NP-1:0]                mask;

  // Folds a MAC address into a table index
  function automatic logic [lse_pkg::TBL_AW-1:0] lse_hash(input logic [lse_pkg::MAC_W-1:0] m);
    return m[47:36] ^ m[35:24] ^ m[23:12] ^ m[11:0];
  endfunction

  // One-hot mask of a port number
  function automatic logic [NP-1:0] lse_onehot(input logic [lse_pkg::PW-1:0] p);
    return NP'(1) << p;
  endfunction

  // Table port: single write, synchronous read one cycle after the address
  always_ff @(posedge CLK_SYS) begin
    if (we) begin
      tbl[wa] <= wd;
    end
    rd_q <= tbl[ra];
  end

  // Handshakes are combinational; decision data sits in the queue flops
  assign RX_READY    = (s_q.st == lse_pkg::ST_IDLE) && !TBL_WE && (s_q.hn != 2'h2);
  assign TBL_ACK     = (s_q.st == lse_pkg::ST_MGMT);
  assign FWD_VALID   = (s_q.hn != 2'h0) || (s_q.ln != 2'h0);
  assign FWD_HIGH    = (s_q.hn != 2'h0);
  assign FWD_HANDLE  = FWD_HIGH ? s_q.hq[0].hdl : s_q.lq[0].hdl;
  assign FWD_PORTS   = FWD_HIGH ? s_q.hq[0].ports : s_q.lq[0].ports;
  assign DROP_VALID  = s_q.drop_v;
  assign DROP_HANDLE = s_q.drop_h;
  assign PAUSE_REQ   = s_q.pause;
  assign JAM_REQ     = s_q.jam;
  assign LEARN_COUNT = s_q.n_learn;
  assign INIT_DONE   = (s_q.st != lse_pkg::ST_CLEAR);

  // Next-state logic for the whole engine
  always_comb begin
    s_d      = s_q;
    we       = 1'b0;
    wa       = '0;
    wd       = '0;
    ra       = '0;
    hit      = 1'b0;
    hi       = 1'b0;
    bcast    = 1'b0;
    mask     = '0;
    s_d.drop_v = 1'b0;

    // Free-running timers; a sweep tick waits until the engine is idle
    s_d.sec_cnt = (s_q.sec_cnt >= SEC_CYC - 32'h1) ? 32'h0 : s_q.sec_cnt + 32'h1;
    s_d.swp_cnt = (s_q.swp_cnt >= SWEEP_CYC - 32'h1) ? 32'h0 : s_q.swp_cnt + 32'h1;
    if (s_q.swp_cnt >= SWEEP_CYC - 32'h1) begin
      s_d.swp_pend = 1'b1;
    end
    if (s_q.sec_cnt >= SEC_CYC - 32'h1) begin
      s_d.bc_cnt = '0;
    end

    // Strict priority pop: low queue drains only when high is empty
    pop_h = FWD_READY && (s_q.hn != 2'h0);
    pop_l = FWD_READY && (s_q.hn == 2'h0) && (s_q.ln != 2'h0);
    if (pop_h) begin
      s_d.hq[0] = s_q.hq[1];
      s_d.hn    = s_q.hn - 2'h1;
    end
    if (pop_l) begin
      s_d.lq[0] = s_q.lq[1];
      s_d.ln    = s_q.ln - 2'h1;
    end

    // Overload on any egress queue or a full high queue throttles ingress
    near      = (|EGR_NEAR_FULL) || (s_q.hn == 2'h2);
    s_d.pause = FC_EN & FDX & {NP{near}};
    s_d.jam   = FC_EN & ~FDX & {NP{near}};

    case (s_q.st)
      // Walk the whole table invalidating entries after reset
      lse_pkg::ST_CLEAR: begin
        we          = 1'b1;
        wa          = s_q.ptr;
        s_d.ptr     = s_q.ptr + 12'h001;
        s_d.n_learn = '0;
        if (s_q.ptr == lse_pkg::TBL_LAST) begin
          s_d.st = lse_pkg::ST_IDLE;
        end
      end
      // Management first, then frames, then aging; steady frames or writes can hold aging off
      lse_pkg::ST_IDLE: begin
        if (TBL_WE) begin
          ra     = lse_hash(TBL_MAC);
          s_d.st = lse_pkg::ST_MGMT;
        end else if (RX_VALID && RX_READY) begin
          s_d.f_hdl  = RX_HANDLE;
          s_d.f_port = RX_PORT;
          s_d.f_bad  = (RX_LEN > lse_pkg::MAX_LEN) || (RX_LEN < lse_pkg::MIN_LEN) || !RX_CRC_OK;
          s_d.f_tag  = RX_TAGGED;
          s_d.f_pcp  = RX_PCP;
          s_d.f_vid  = RX_VID;
          s_d.f_da   = RX_DA;
          s_d.f_sa   = RX_SA;
          ra         = lse_hash(RX_DA);
          s_d.st     = lse_pkg::ST_LKDA;
        end else if (s_q.swp_pend) begin
          ra           = s_q.ptr;
          s_d.swp_pend = 1'b0;
          s_d.st       = lse_pkg::ST_AGE;
        end
      end
      // Install a configured entry; it wins over whatever learned entry sat there
      lse_pkg::ST_MGMT: begin
        we       = 1'b1;
        wa       = lse_hash(TBL_MAC);
        wd.valid = 1'b1;
        wd.kind  = TBL_AGENT ? lse_pkg::KIND_AGENT : lse_pkg::KIND_STATIC;
        wd.mac   = TBL_MAC;
        wd.ports = TBL_PORTS;
        wd.drop  = TBL_DROP;
        if (rd_q.valid && (rd_q.kind == lse_pkg::KIND_LEARN)) begin
          s_d.n_learn = s_q.n_learn - 12'h001;
        end
        s_d.st = lse_pkg::ST_IDLE;
      end
      // Destination entry is back; start the source lookup
      lse_pkg::ST_LKDA: begin
        s_d.da_ent = (rd_q.valid && (rd_q.mac == s_q.f_da)) ? rd_q : '0;
        ra         = lse_hash(s_q.f_sa);
        s_d.st     = lse_pkg::ST_LKSA;
      end
      // Learn the source, then build and queue the decision
      lse_pkg::ST_LKSA: begin
        if (!s_q.f_bad && !s_q.f_sa[lse_pkg::MCAST_BIT]
            && !(MIR_EN && (s_q.f_port == MIR_DST))) begin
          wa       = lse_hash(s_q.f_sa);
          wd.valid = 1'b1;
          wd.kind  = lse_pkg::KIND_LEARN;
          wd.mac   = s_q.f_sa;
          wd.ports = lse_onehot(s_q.f_port);
          if (rd_q.valid && (rd_q.kind != lse_pkg::KIND_LEARN)) begin
            we = 1'b0;
          end else if (rd_q.valid) begin
            we = 1'b1;
          end else if (s_q.n_learn < lse_pkg::TBL_MAX) begin
            we          = 1'b1;
            s_d.n_learn = s_q.n_learn + 12'h001;
          end
        end
        hit   = s_q.da_ent.valid;
        bcast = (s_q.f_da == lse_pkg::BCAST_MAC);
        // Unknown, multicast and broadcast flood unless a filter entry says otherwise
        if (hit) begin
          mask = s_q.da_ent.drop ? '0 : s_q.da_ent.ports;
        end else begin
          mask = '1;
        end
        if (VLAN_EN && s_q.f_tag && (s_q.f_vid != '0) && (s_q.f_vid == VLAN_ID)) begin
          mask = mask & VLAN_PORTS;
        end
        mask = mask & ~lse_onehot(s_q.f_port);
        if (MIR_EN && ((s_q.f_port == MIR_SRC) || mask[MIR_SRC])) begin
          mask = mask | lse_onehot(MIR_DST);
        end
        if (MIR_EN && (s_q.f_port == MIR_DST)) begin
          mask = '0;
        end
        hi = s_q.f_tag && s_q.f_pcp[lse_pkg::PCP_HI_BIT];
        if (!hi) begin
          mask = mask & ~EGR_NEAR_FULL;
        end
        // Limiter checks the count reached so far this second
        for (int p = 0; p < NP; p++) begin
          if (BCL_EN && bcast && (s_q.bc_cnt[p] >= BCL_MAX[p])) begin
            mask[p] = 1'b0;
          end
        end
        if (s_q.f_bad || (mask == '0) || (!hi && (s_d.ln == 2'h2))) begin
          s_d.drop_v = 1'b1;
          s_d.drop_h = s_q.f_hdl;
        end else begin
          if (hi) begin
            s_d.hq[s_d.hn[0]] = '{hdl: s_q.f_hdl, ports: mask};
            s_d.hn            = s_d.hn + 2'h1;
          end else begin
            s_d.lq[s_d.ln[0]] = '{hdl: s_q.f_hdl, ports: mask};
            s_d.ln            = s_d.ln + 2'h1;
          end
          if (bcast) begin
            for (int p = 0; p < NP; p++) begin
              if (mask[p]) begin
                s_d.bc_cnt[p] = s_d.bc_cnt[p] + 16'h0001;
              end
            end
          end
        end
        s_d.st = lse_pkg::ST_IDLE;
      end
      // Age one learned entry; static and agent entries never age
      lse_pkg::ST_AGE: begin
        wa      = s_q.ptr;
        s_d.ptr = s_q.ptr + 12'h001;
        if (rd_q.valid && (rd_q.kind == lse_pkg::KIND_LEARN)) begin
          we = 1'b1;
          if (rd_q.age == lse_pkg::AGE_LIMIT) begin
            wd          = '0;
            s_d.n_learn = s_q.n_learn - 12'h001;
          end else begin
            wd     = rd_q;
            wd.age = rd_q.age + 2'h1;
          end
        end
        s_d.st = lse_pkg::ST_IDLE;
      end
      default: begin
        s_d.st = lse_pkg::ST_CLEAR;
      end
    endcase
  end

  // State register; synchronous reset restarts the table clear
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ===== test/lse_engine_chk.sv
// Port assertions of the switching engine
`timescale 1ns/10ps
module lse_engine_chk (
  input wire logic        CLK_SYS,
  input wire logic        NRST,
  input wire logic        RX_VALID,
  input wire logic        RX_READY,
  input wire logic [7:0]  RX_HANDLE,
  input wire logic [2:0]  RX_PORT,
  input wire logic [10:0] RX_LEN,
  input wire logic        RX_CRC_OK,
  input wire logic        FWD_VALID,
  input wire logic        FWD_READY,
  input wire logic [7:0]  FWD_HANDLE,
  input wire logic [6:0]  FWD_PORTS,
  input wire logic        FWD_HIGH,
  input wire logic        DROP_VALID,
  input wire logic [7:0]  DROP_HANDLE,
  input wire logic        MIR_EN,
  input wire logic [2:0]  MIR_DST,
  input wire logic [6:0]  FC_EN,
  input wire logic [6:0]  FDX,
  input wire logic [6:0]  EGR_NEAR_FULL,
  input wire logic [6:0]  PAUSE_REQ,
  input wire logic [6:0]  JAM_REQ,
  input wire logic [11:0] LEARN_COUNT,
  input wire logic        INIT_DONE
);
  // All checks run on the system clock; all but chk_reset_clear rest while reset is low
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);

  // Frame screening and drop reporting
  chk_bad_drop: assert property (RX_VALID && RX_READY && (!RX_CRC_OK || RX_LEN > lse_pkg::MAX_LEN ||
    RX_LEN < lse_pkg::MIN_LEN) |-> ##3 DROP_VALID && DROP_HANDLE == $past(RX_HANDLE, 3)) else $error("bad frame kept");
  chk_drop_pulse: assert property (DROP_VALID |=> !DROP_VALID)
    else $error("drop pulse too long");
  chk_mirror_drop: assert property (RX_VALID && RX_READY && MIR_EN && RX_PORT == MIR_DST
    |-> ##3 DROP_VALID && DROP_HANDLE == $past(RX_HANDLE, 3)) else $error("mirror port frame kept");
  // A waiting high decision stays at the head until taken
  chk_high_hold: assert property (FWD_VALID && FWD_HIGH && !FWD_READY
    |=> FWD_VALID && FWD_HIGH && $stable(FWD_HANDLE) && $stable(FWD_PORTS)) else $error("high head lost");
  // Flow control requests one cycle after overload, split by duplex mode
  chk_pause_fdx: assert property (|EGR_NEAR_FULL |=> PAUSE_REQ == ($past(FC_EN) & $past(FDX)))
    else $error("pause request wrong");
  chk_jam_hdx: assert property (|EGR_NEAR_FULL |=> JAM_REQ == ($past(FC_EN) & ~$past(FDX)))
    else $error("jam request wrong");
  // Table occupancy and clearing
  chk_table_cap: assert property (LEARN_COUNT <= lse_pkg::TBL_MAX)
    else $error("count above capacity");
  chk_reset_clear: assert property (disable iff (1'b0) !NRST |=> LEARN_COUNT == 12'h000 && !INIT_DONE
    && !FWD_VALID) else $error("reset left table state");
  chk_init_block: assert property (!INIT_DONE |-> !RX_READY)
    else $error("frames taken before table clear");
endmodule

bind lse_engine lse_engine_chk chk_u (.*);

// ===== test/lse_mac_model.sv
// Egress MAC model: takes forward decisions, may stall, reports each one taken
`timescale 1ns/10ps
module lse_mac_model (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       stall,
  input  wire logic       fwd_valid,
  output logic            fwd_ready,
  input  wire logic [7:0] fwd_handle,
  input  wire logic [6:0] fwd_ports,
  input  wire logic       fwd_high,
  output logic            got,
  output logic [7:0]      got_handle,
  output logic [6:0]      got_ports,
  output logic            got_high
);
  // Ready follows the stall request alone, so a stall only delays a decision
  assign fwd_ready = !stall;
  // Report what was taken at each accepting edge
  always_ff @(posedge clk_sys) begin
    got <= nrst && fwd_valid && fwd_ready;
    got_handle <= fwd_handle;
    got_ports <= fwd_ports;
    got_high <= fwd_high;
  end
endmodule

// ===== test/lse_engine_bench.sv
// Scenario bench of the switching engine with an egress MAC model
`timescale 1ns/10ps
module lse_engine_bench;
  logic CLK_SYS, NRST, RX_VALID, RX_READY, RX_CRC_OK, RX_TAGGED, FWD_VALID, FWD_READY, FWD_HIGH, DROP_VALID;
  logic TBL_WE, TBL_ACK, TBL_AGENT, TBL_DROP, VLAN_EN, MIR_EN, BCL_EN, INIT_DONE, stall, got, got_high;
  logic [7:0]       RX_HANDLE, FWD_HANDLE, DROP_HANDLE, got_handle;
  logic [2:0]       RX_PORT, RX_PCP, MIR_SRC, MIR_DST;
  logic [10:0]      RX_LEN;
  logic [11:0]      RX_VID, VLAN_ID, LEARN_COUNT;
  logic [47:0]      RX_DA, RX_SA, TBL_MAC;
  logic [6:0]       FWD_PORTS, TBL_PORTS, VLAN_PORTS, FC_EN, FDX, EGR_NEAR_FULL, PAUSE_REQ, JAM_REQ, got_ports;
  logic [6:0][15:0] BCL_MAX;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  localparam logic [47:0] MA = 48'h0200_0000_0A01, MB = 48'h0200_0000_0B02, MC = 48'h0200_0000_0C03;
  localparam logic [47:0] MD = 48'h0200_0000_0D04, UNK = 48'h0A00_0000_00F0, BC = lse_pkg::BCAST_MAC;
  localparam logic [10:0] LENS [6] = '{11'h5F2, 11'h5F3, 11'h040, 11'h03F, 11'h064, 11'h7FF};

  // Short sweep and limiter window keep the run brief
  lse_engine #(.SWEEP_CYC(2), .SEC_CYC(2000)) dut_u (.*);
  lse_mac_model mac_u (.clk_sys(CLK_SYS), .nrst(NRST), .stall(stall), .fwd_valid(FWD_VALID), .fwd_ready(FWD_READY),
    .fwd_handle(FWD_HANDLE), .fwd_ports(FWD_PORTS), .fwd_high(FWD_HIGH), .got(got), .got_handle(got_handle),
    .got_ports(got_ports), .got_high(got_high));

  // Clock of 10 ns
  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end

  // Cycle ceiling above two table clears, the aging wait and traffic
  always @(posedge CLK_SYS) begin
    cyc <= cyc + 1;
    if (cyc == 50000) begin
      error_cnt++;
      $display("mismatch at %0t: run did not finish", $time);
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  // Summary held until taken; a spare edge parts two requests
  task automatic send(input logic [2:0] p, input logic [47:0] da, sa, input logic [7:0] h);
    logic r;
    int n;
    {RX_VALID, RX_PORT, RX_DA, RX_SA, RX_HANDLE} = {1'b1, p, da, sa, h};
    n = 0;
    do begin
      @(negedge CLK_SYS) r = RX_READY;
      @(posedge CLK_SYS) n++;
    end while (r !== 1'b1 && n < 9000);
    #1 RX_VALID = 1'b0;
    @(posedge CLK_SYS) #1;
  endtask

  // Waits for a decision or a drop and judges it
  task automatic result(input logic drop, logic [7:0] h, logic [6:0] ports, logic hi, string m);
    int n;
    n = 0;
    while (got !== 1'b1 && DROP_VALID !== 1'b1 && n < 40) @(posedge CLK_SYS) #1 n++;
    if (drop) chk(DROP_VALID === 1'b1 && DROP_HANDLE === h, m);
    else chk(got === 1'b1 && got_handle === h && got_ports === ports && got_high === hi, m);
    @(posedge CLK_SYS) #1;
  endtask

  task automatic tbl_write(input logic [47:0] m, input logic [6:0] p, input logic ag, dr);
    logic a;
    int n;
    {TBL_WE, TBL_MAC, TBL_PORTS, TBL_AGENT, TBL_DROP} = {1'b1, m, p, ag, dr};
    n = 0;
    do begin
      @(negedge CLK_SYS) a = TBL_ACK;
      @(posedge CLK_SYS) n++;
    end while (a !== 1'b1 && n < 50);
    #1 TBL_WE = 1'b0;
    chk(a === 1'b1, "table write not acknowledged");
  endtask

  task automatic do_reset;
    int n;
    NRST = 1'b0;
    repeat (6) @(posedge CLK_SYS);
    #1 NRST = 1'b1;
    chk(LEARN_COUNT === 12'h000 && INIT_DONE === 1'b0, "reset state wrong");
    n = 0;
    while (INIT_DONE !== 1'b1 && n < 6000) @(posedge CLK_SYS) #1 n++;
    chk(INIT_DONE === 1'b1, "table clear did not finish");
  endtask

  // Length boundaries and checksum; good frames flood from port 0
  task automatic t_checks;
    for (int i = 0; i < 6; i++) begin
      RX_LEN = LENS[i];
      RX_CRC_OK = (i != 4);
      send(3'h0, UNK, MA + i + 1, 8'(i));
      result(i[0] || i == 4, 8'(i), 7'h7E, 1'b0, "frame screening");
    end
    {RX_CRC_OK, RX_LEN} = {1'b1, 11'h064};
  endtask

  task automatic t_learn;
    send(3'h1, UNK, MA, 8'h10);
    result(1'b0, 8'h10, 7'h7D, 1'b0, "unknown destination not flooded");
    send(3'h2, MA, MC, 8'h11);
    result(1'b0, 8'h11, 7'h02, 1'b0, "known destination misrouted");
    send(3'h4, BC, MC + 1, 8'h12);
    result(1'b0, 8'h12, 7'h6F, 1'b0, "broadcast not flooded");
  endtask

  // Static entry survives a learning attempt; agent entry rejects
  task automatic t_static;
    tbl_write(MB, 7'h10, 1'b0, 1'b0);
    send(3'h3, UNK, MB, 8'h13);
    result(1'b0, 8'h13, 7'h77, 1'b0, "flood from port 3 wrong");
    send(3'h0, MB, MA + 9, 8'h14);
    result(1'b0, 8'h14, 7'h10, 1'b0, "static entry lost");
    tbl_write(MD, 7'h7F, 1'b1, 1'b1);
    send(3'h0, MD, MA + 9, 8'h15);
    result(1'b1, 8'h15, 7'h00, 1'b0, "reject filter not applied");
  endtask

  task automatic t_prio;
    {VLAN_EN, VLAN_ID, VLAN_PORTS, RX_TAGGED, RX_PCP, RX_VID} = {1'b1, 12'h005, 7'h0C, 1'b1, 3'h3, 12'h007};
    send(3'h0, UNK, MA + 1, 8'h20);
    result(1'b0, 8'h20, 7'h7E, 1'b0, "priority 3 not low");
    RX_PCP = 3'h4;
    send(3'h0, UNK, MA + 1, 8'h21);
    result(1'b0, 8'h21, 7'h7E, 1'b1, "priority 4 not high");
    {RX_PCP, RX_VID} = {3'h5, 12'h005};
    send(3'h2, BC, MC + 1, 8'h22);
    result(1'b0, 8'h22, 7'h08, 1'b1, "vlan member set not applied");
    RX_VID = 12'h000;
    send(3'h0, UNK, MA + 1, 8'h23);
    result(1'b0, 8'h23, 7'h7E, 1'b1, "priority tagged frame wrong");
    {VLAN_EN, RX_TAGGED} = 2'b00;
  endtask

  // Stalled egress: full low queue drops, a later high frame still leaves first
  task automatic t_queue;
    stall = 1'b1;
    send(3'h0, UNK, MA + 1, 8'h30);
    send(3'h0, UNK, MA + 1, 8'h31);
    send(3'h0, UNK, MA + 1, 8'h32);
    result(1'b1, 8'h32, 7'h00, 1'b0, "low frame kept with its queue full");
    {RX_TAGGED, RX_PCP} = {1'b1, 3'h6};
    send(3'h0, UNK, MA + 1, 8'h33);
    repeat (3) @(posedge CLK_SYS);
    #1 stall = 1'b0;
    result(1'b0, 8'h33, 7'h7E, 1'b1, "high frame not sent first");
    result(1'b0, 8'h30, 7'h7E, 1'b0, "first low frame lost");
    result(1'b0, 8'h31, 7'h7E, 1'b0, "second low frame lost");
    RX_TAGGED = 1'b0;
  endtask

  task automatic t_mirror;
    {MIR_EN, MIR_SRC, MIR_DST} = {1'b1, 3'h1, 3'h6};
    send(3'h1, MC, MA, 8'h40);
    result(1'b0, 8'h40, 7'h44, 1'b0, "source traffic not mirrored");
    send(3'h6, MC, MA + 1, 8'h41);
    result(1'b1, 8'h41, 7'h00, 1'b0, "mirror port frame not blocked");
    MIR_EN = 1'b0;
  endtask

  task automatic t_bcl;
    BCL_MAX = {7{16'h00FF}};
    BCL_MAX[5] = 16'h0001;
    BCL_EN = 1'b1;
    while (cyc % 2000 != 10) @(posedge CLK_SYS);
    #1 send(3'h0, BC, MA + 1, 8'h50);
    result(1'b0, 8'h50, 7'h7E, 1'b0, "first broadcast limited");
    send(3'h0, BC, MA + 1, 8'h51);
    result(1'b0, 8'h51, 7'h5E, 1'b0, "broadcast over limit not rejected");
    BCL_EN = 1'b0;
    send(3'h0, BC, MA + 1, 8'h52);
    result(1'b0, 8'h52, 7'h7E, 1'b0, "limiter active while disabled");
  endtask

  task automatic t_fc;
    {FC_EN, FDX, EGR_NEAR_FULL} = {7'h0F, 7'h03, 7'h10};
    repeat (2) @(posedge CLK_SYS);
    #1 chk(PAUSE_REQ === 7'h03, "pause not requested on full duplex ports");
    chk(JAM_REQ === 7'h0C, "jam not raised on half duplex ports");
    EGR_NEAR_FULL = 7'h00;
    repeat (2) @(posedge CLK_SYS);
    #1 chk(PAUSE_REQ === 7'h00 && JAM_REQ === 7'h00, "flow control held without overload");
  endtask

  // Main sequence; every input has a value at time zero
  initial begin
    {NRST, RX_VALID, RX_TAGGED, TBL_WE, TBL_AGENT, TBL_DROP, VLAN_EN, MIR_EN, BCL_EN, stall} = '0;
    {RX_HANDLE, RX_PORT, RX_PCP, MIR_SRC, MIR_DST, RX_VID, VLAN_ID, RX_DA, RX_SA, TBL_MAC} = '0;
    {TBL_PORTS, VLAN_PORTS, FC_EN, FDX, EGR_NEAR_FULL, BCL_MAX} = '0;
    {RX_CRC_OK, RX_LEN} = {1'b1, 11'h064};
    do_reset();
    t_checks();
    t_learn();
    t_static();
    t_prio();
    t_queue();
    t_mirror();
    t_bcl();
    t_fc();
    do_reset();
    send(3'h0, MA, MC, 8'h60);
    result(1'b0, 8'h60, 7'h7E, 1'b0, "learned entry survived reset");
    repeat (33500) @(posedge CLK_SYS);
    #1 send(3'h1, MC, MD, 8'h61);
    result(1'b0, 8'h61, 7'h7D, 1'b0, "entry not aged out");
    print_verdict();
  end
endmodule
